// ---- hw/tx_err_defs.vh ----
`ifndef TX_ERR_DEFS_VH
`define TX_ERR_DEFS_VH
// register word offsets (byte address = index * 4)
`define REG_TX_STATUS       4'h0
`define REG_CLASH_COUNT     4'h1
`define REG_POLICY          4'h2
`define REG_TX_DATA         4'h3
// status bit positions
`define BIT_JABBER          3
`define BIT_CLASH           2
`define BIT_SIXTEEN         1
`define BIT_WR_TIMEOUT      0
// flag reset value
`define FLAGS_RESET         4'h0
// collision counter field
`define CNT_LSB             4
`define CNT_MSB             7
// policy field (bits 2..1)
`define POL_LSB             1
`define POL_MSB             2
`define POL_RESET           2'h0
// timing
`define CLK_HZ              50000000
`define WR_TIMEOUT_NS       2150
`define WR_TIMEOUT_CYC      ((`WR_TIMEOUT_NS * (`CLK_HZ / 1000000)) / 1000)
`define CLASH_LIMIT         5'h10
`endif

// ---- hw/tx_error_status_flags.v ----
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "tx_err_defs.vh"
module tx_error_status_flags #(
  parameter JABBER_CYC = 1000000
) (
  // clock and reset
  input  wire        i_clk_sys,
  input  wire        i_rst,
  // avalon-mm slave
  input  wire [3:0]  i_address,
  input  wire        i_read,
  input  wire        i_write,
  input  wire [31:0] i_writedata,
  output reg  [31:0] o_readdata,
  output reg         o_waitrequest,
  // transmitter events
  input  wire        i_tx_active,
  input  wire        i_collision,
  input  wire        i_tx_start,
  input  wire        i_buf_full,
  // transmitter control
  output reg         o_tx_suspend,
  output reg         o_tx_retry,
  output reg         o_tx_abort_pkt,
  output reg         o_tx_hold,
  output reg         o_buf_wr
);
////////////////////////////////////////////////////////////////////////
// pin synchronisers: network side is asynchronous to the bus clock
// vector order: 0 transmit active, 1 collision, 2 start, 3 buffer full
localparam N_PINS = 4;
wire [N_PINS-1:0] pin_raw;
wire [N_PINS-1:0] pin_sync;
assign pin_raw = {i_buf_full, i_tx_start, i_collision, i_tx_active};
// two stages per pin; only the second stage feeds any logic
genvar g;
generate
  for (g = 0; g < N_PINS; g = g + 1) begin : g_sync
    reg meta;
    reg stable;
    always @(posedge i_clk_sys) begin
      meta   <= pin_raw[g];
      stable <= meta;
    end
    assign pin_sync[g] = stable;
  end
endgenerate
wire tx_act   = pin_sync[0];
wire tx_start = pin_sync[2];
wire buf_full = pin_sync[3];
////////////////////////////////////////////////////////////////////////
// collision edge detector; resets to the idle level of the pin so
// that no false collision follows reset
reg  col_q;
always @(posedge i_clk_sys) begin
  if (i_rst)
    col_q <= 1'b0;
  else
    col_q <= pin_sync[1];
end
wire col_pulse = pin_sync[1] & ~col_q;
////////////////////////////////////////////////////////////////////////
// bus slave state, one-hot
localparam S_IDLE = 3'b001;
localparam S_WAIT = 3'b010;
localparam S_ACK  = 3'b100;
// status and counter storage
reg [2:0]  state;
reg [11:0] wr_cnt;
reg [3:0]  flags;
reg [4:0]  clash_cnt;
reg [1:0]  policy;
// wide watchdog counter, sized for the default limit of a million cycles
reg [31:0] jab_cnt;
// register index decode, shared by the write strobes and policy load
function reg_hit;
  input [3:0] a;
  input [3:0] idx;
  begin
    reg_hit = (a == idx);
  end
endfunction
// request decode; strobes only count while the slave is idle
wire       sel_stat = reg_hit(i_address, `REG_TX_STATUS);
wire       wr_stat  = i_write & sel_stat & (state == S_IDLE);
wire       data_wr  = i_write & reg_hit(i_address, `REG_TX_DATA);
// timeout on the last allowed wait cycle of 2.15 us
wire       timeout  = (wr_cnt >= `WR_TIMEOUT_CYC - 1);
// watchdog trips at its limit while the transmitter is still active
wire       jab_hit  = tx_act & (jab_cnt >= JABBER_CYC - 1);
wire       sixteen  = col_pulse & tx_act &
                      (clash_cnt == `CLASH_LIMIT - 5'h01);
wire       drop_wr  = (state == S_WAIT) & buf_full & timeout;
// clear mask only for written ones
wire [3:0] clr = wr_stat ? i_writedata[3:0] : 4'h0;
// events of this cycle, one bit per flag
wire [3:0] set;
assign set[`BIT_JABBER]     = jab_hit;
assign set[`BIT_CLASH]      = col_pulse & tx_act;
assign set[`BIT_SIXTEEN]    = sixteen;
assign set[`BIT_WR_TIMEOUT] = drop_wr;
// read mux shared by the read path
function [31:0] rd_mux;
  input [3:0] a;
  begin
    case (a)
      `REG_TX_STATUS:   rd_mux = {28'h000_0000, flags};
      `REG_CLASH_COUNT:
        rd_mux = {24'h00_0000, clash_cnt[3:0], 4'h0};
      `REG_POLICY:      rd_mux = {29'h0000_0000, policy, 1'b0};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end
endfunction
////////////////////////////////////////////////////////////////////////
// bus handshake; data writes wait for buffer room up to the timeout
// waitrequest is low for exactly one cycle; a 12-bit wait counter
// covers the timeout for clocks well beyond a gigahertz
always @(posedge i_clk_sys) begin
  if (i_rst) begin
    state         <= S_IDLE;
    wr_cnt        <= 12'h000;
    o_waitrequest <= 1'b1;
    o_readdata    <= 32'h0000_0000;
    o_buf_wr      <= 1'b0;
  end else begin
    o_buf_wr      <= 1'b0;
    o_waitrequest <= 1'b1;
    case (state)
      // register accesses answer on the next cycle
      S_IDLE: begin
        wr_cnt <= 12'h000;
        if (data_wr)
          state <= S_WAIT;
        else if (i_read | i_write) begin
          o_readdata    <= rd_mux(i_address);
          o_waitrequest <= 1'b0;
          state         <= S_ACK;
        end
      end
      // buffer room or the timeout ends the wait
      S_WAIT: begin
        wr_cnt <= wr_cnt + 12'h001;
        if (!buf_full | timeout) begin
          o_buf_wr      <= ~buf_full; // dropped on timeout
          o_waitrequest <= 1'b0;
          state         <= S_ACK;
        end
      end
      S_ACK:   state <= S_IDLE;
      default: state <= S_IDLE;
    endcase
  end
end
////////////////////////////////////////////////////////////////////////
// sticky flags: a set in the clearing cycle wins
// only the host clears a flag; the transmitter can only raise it
always @(posedge i_clk_sys) begin
  if (i_rst)
    flags <= `FLAGS_RESET;
  else
    flags <= (flags & ~clr) | set;
end
////////////////////////////////////////////////////////////////////////
// policy register write
always @(posedge i_clk_sys) begin
  if (i_rst)
    policy <= `POL_RESET;
  else if (i_write & (state == S_IDLE) & reg_hit(i_address, `REG_POLICY))
    // other bits of the written word are ignored
    policy <= i_writedata[`POL_MSB:`POL_LSB];
end
////////////////////////////////////////////////////////////////////////
// jabber watchdog and collision counting
always @(posedge i_clk_sys) begin
  if (i_rst) begin
    jab_cnt        <= 32'h0000_0000;
    clash_cnt      <= 5'h00;
    o_tx_suspend   <= 1'b0;
    o_tx_retry     <= 1'b0;
    o_tx_abort_pkt <= 1'b0;
    o_tx_hold      <= 1'b0;
  end else begin
    o_tx_retry     <= 1'b0;
    o_tx_abort_pkt <= 1'b0;
    jab_cnt <= tx_act ? jab_cnt + 32'h0000_0001 : 32'h0000_0000;
    // suspend holds until the transmitter drops its active line
    if (jab_hit)
      o_tx_suspend <= 1'b1;
    else if (!tx_act)
      o_tx_suspend <= 1'b0;
    // the count belongs to one packet and restarts with the next
    if (tx_start)
      clash_cnt <= 5'h00;
    // clear before the sixteenth check so a new hold in that cycle wins
    if (wr_stat & i_writedata[`BIT_SIXTEEN])
      o_tx_hold <= 1'b0;
    if (sixteen) begin
      clash_cnt <= 5'h00;
      // policy 0 skip packet, 1 hold for host, else retry anew
      case (policy)
        2'h0:    o_tx_abort_pkt <= 1'b1;
        2'h1:    o_tx_hold      <= 1'b1;
        default: o_tx_retry     <= 1'b1;
      endcase
    end else if (col_pulse & tx_act) begin
      clash_cnt  <= clash_cnt + 5'h01;
      o_tx_retry <= 1'b1;
    end
  end
end
endmodule // tx_error_status_flags

// ---- dv/tx_line_model.sv ----
`timescale 1ns/1ps
// far side: transmitter, medium and buffer state
module tx_line_model (
  input  wire i_clk_sys,
  output reg  o_tx_active,
  output reg  o_collision,
  output reg  o_tx_start,
  output reg  o_buf_full
);
  initial {o_tx_active, o_collision, o_tx_start, o_buf_full} = 4'h0;
  // pulses last 4 cycles so the 2-stage sync always sees them
  task packet(input int n, input int c);
    begin
      @(posedge i_clk_sys);
      o_tx_start <= 1'b1;
      o_tx_active <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
      o_tx_start <= 1'b0;
      repeat (n) begin
        o_collision <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        o_collision <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
      end
      repeat (c) @(posedge i_clk_sys);
      o_tx_active <= 1'b0;
      repeat (4) @(posedge i_clk_sys);
    end
  endtask
  task set_full(input logic f);
    o_buf_full <= f;
  endtask
endmodule // tx_line_model

// ---- dv/tx_error_status_flags_assertions.sv ----
`timescale 1ns/1ps
module tx_flags_checker (
  input wire       i_clk_sys,
  input wire       i_rst,
  input wire [3:0] i_address,
  input wire       i_read,
  input wire       i_write,
  input wire       i_tx_active,
  input wire       o_waitrequest,
  input wire       o_tx_suspend,
  input wire       o_tx_retry,
  input wire       o_tx_abort_pkt,
  input wire       o_tx_hold,
  input wire       o_buf_wr
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // outputs are quiet on the first edge after reset
  rst_quiet_a: assert property ($past(i_rst) |-> o_waitrequest &&
    !o_buf_wr && !o_tx_suspend && !o_tx_hold) else $error("reset outputs");
  ack_pulse_a: assert property (!o_waitrequest |=> o_waitrequest)
    else $error("ack not one cycle");
  reg_ack_a: assert property ($rose(i_read) |->
    ##[1:4] !o_waitrequest) else $error("read not answered");
  wr_bound_a: assert property ($rose(i_write) && i_address == 4'h3
    |-> ##[1:120] !o_waitrequest) else $error("data write hangs");
  buf_pulse_a: assert property (o_buf_wr |=> !o_buf_wr)
    else $error("buffer write stuck");
  jab_cause_a: assert property ($rose(o_tx_suspend) |->
    $past(i_tx_active, 5)) else $error("suspend without transmit");
  retry_pulse_a: assert property (o_tx_retry |=> !o_tx_retry)
    else $error("retry stuck");
  one_action_a: assert property (o_tx_abort_pkt |-> !o_tx_retry)
    else $error("abort with retry");
  cover property (o_tx_abort_pkt);
  cover property (o_tx_hold);
  cover property ($rose(o_tx_suspend));
endmodule // tx_flags_checker
bind tx_error_status_flags tx_flags_checker chk_i (.*);

// ---- dv/tx_error_status_flags_tb.sv ----
`timescale 1ns/1ps
module tx_error_status_flags_tb;
  logic        i_clk_sys, i_rst, i_read, i_write;
  logic [3:0]  i_address;
  logic [31:0] i_writedata, o_readdata, q, n_fail, num_checks;
  logic [31:0] n_retry, n_abort, n_wr, r0, a0;
  logic        susp_seen;
  logic        o_waitrequest, o_tx_suspend, o_tx_retry;
  logic        o_tx_abort_pkt, o_tx_hold, o_buf_wr;
  wire         act, col, start, full;
  int          p;
  tx_line_model line (.i_clk_sys(i_clk_sys), .o_tx_active(act),
    .o_collision(col), .o_tx_start(start), .o_buf_full(full));
  tx_error_status_flags #(.JABBER_CYC(400)) dut (.i_clk_sys(i_clk_sys),
    .i_rst(i_rst), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_tx_active(act), .i_collision(col),
    .i_tx_start(start), .i_buf_full(full), .o_tx_suspend(o_tx_suspend),
    .o_tx_retry(o_tx_retry), .o_tx_abort_pkt(o_tx_abort_pkt),
    .o_tx_hold(o_tx_hold), .o_buf_wr(o_buf_wr));
  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  // count control pulses seen at the transmitter side
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      {n_retry, n_abort, n_wr} <= 96'h0;
      susp_seen <= 1'b0;
    end else begin
      n_retry <= n_retry + (o_tx_retry === 1'b1);
      n_abort <= n_abort + (o_tx_abort_pkt === 1'b1);
      n_wr <= n_wr + (o_buf_wr === 1'b1);
      susp_seen <= susp_seen | (o_tx_suspend === 1'b1);
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // request held until waitrequest is sampled low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    {i_address, i_writedata, i_read, i_write} <= {a, d, !w, w};
    @(posedge i_clk_sys);
    while (o_waitrequest !== 1'b0) @(posedge i_clk_sys);
    q = o_readdata;
    {i_read, i_write} <= 2'b00;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    // tests need about 1,300 cycles; this allows 10,000
    #200_000 n_fail++;
    conclude;
  end
  initial begin
    {i_rst, i_read, i_write, i_address, i_writedata} = {3'b100, 36'h0};
    {n_fail, num_checks} = 64'h0;
    repeat (5) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    rd(4'h0, 32'h0000_0000);
    line.packet(0, 450);
    rd(4'h0, 32'h0000_0008);
    chk(susp_seen, 32'h0000_0001);
    chk(o_tx_suspend, 32'h0000_0000);
    line.packet(3, 4);
    rd(4'h1, 32'h0000_0030);
    rd(4'h0, 32'h0000_000c);
    chk(n_retry, 32'h0000_0003);
    bus(1'b1, 4'h0, 32'h0000_0004);
    rd(4'h0, 32'h0000_0008);
    bus(1'b1, 4'h0, 32'h0000_0008);
    // each policy in turn after a full run of collisions
    for (p = 0; p < 4; p++) begin
      bus(1'b1, 4'h2, p << 1);
      rd(4'h2, p << 1);
      {r0, a0} = {n_retry, n_abort};
      line.packet(16, 4);
      rd(4'h0, 32'h0000_0006);
      rd(4'h1, 32'h0000_0000);
      chk(n_abort - a0, p == 0);
      chk(o_tx_hold, p == 1);
      chk(n_retry - r0, p > 1 ? 16 : 15);
      bus(1'b1, 4'h0, 32'h0000_0006);
    end
    bus(1'b1, 4'h3, 32'h0000_00a5);
    // the pulse from the answer edge is counted one edge later
    @(posedge i_clk_sys);
    chk(n_wr, 32'h0000_0001);
    line.set_full(1'b1);
    bus(1'b1, 4'h3, 32'h0000_005a);
    chk(n_wr, 32'h0000_0001);
    rd(4'h0, 32'h0000_0001);
    line.set_full(1'b0);
    bus(1'b1, 4'h0, 32'h0000_0001);
    rd(4'h0, 32'h0000_0000);
    rd(4'h5, 32'h0000_0000);
    conclude;
  end
endmodule // tx_error_status_flags_tb
